/* hdl/gan_driver_ctrl.sv */
// Chosen here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "gdrv_cfg.svh"
// Behaviour
// - pin grounded selects 150 v/ns
// - pin on 5v rail selects 100 v/ns
// - rail tie checked once, then pin ignored
// - else resistor code filtered into 15..150
// - temperature pwm at 9 khz, same refresh
// - high pulse never shorter than 30 ns
// - duty spans about 3% to 80%
// - duty linear: t = 162.3 d + 20.1
// - above 150 c duty keeps rising
// - overtemperature holds output high, hysteresis
// - gate falling edge enters state 1
// - state 1 blanks then always goes 2
// - state 2 off, first shutdown state
// - negative drain moves state 2 to 3
// - state 3 on; forward current back to 2
// - fault flag low while supply rising
// - rails pause below fall, resume above rise
// - rails ready releases fault, follow gate
// - two flags encode fault type
module gan_driver_ctrl
    import gdrv_pkg::*;
#(
    parameter int BLANK_CYC = `BLANK_CYC_DEFAULT
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // device side
    input  wire logic        gate_in,
    input  wire sense_t      sense,
    input  wire strap_t      slew_select_pin,
    input  wire logic [11:0] temp_code,
    output logic             switch_on,
    output logic             thermal_shutdown,
    output logic             temp_pwm,
    output logic             fault_n,
    output logic             overcurrent_flag_n,
    output logic [7:0]       slew_setting
);

    // register-based state
    logic [11:0] ot_trip_ff;          // trip threshold, temp code
    logic [11:0] ot_clear_ff;         // clear threshold, lower for hysteresis
    logic [15:0] blank_ff;            // blanking length, software tunable
    logic        ctrl_ff;             // spare control bit
    logic        thermal_shutdown_ff; // overtemperature latch
    logic        rail_lock_ff;        // strap found on rail at power-up
    logic        strap_done_ff;       // one-time strap check performed
    logic [15:0] slew_acc_ff;         // filtered resistor code, fixed point
    logic [7:0]  slew_ff;             // applied slew setting
    logic [13:0] per_cnt_ff;          // pwm period counter
    logic [13:0] duty_ff;             // latched duty threshold
    logic        temp_pwm_ff;         // registered temperature output
    logic        gate_d_ff;           // gate input delayed for edge
    logic [15:0] blank_cnt_ff;        // blanking down counter
    idm_state_t  idm_ff;              // ideal-diode state
    pwr_state_t  pwr_ff;              // power-up state
    logic        switch_on_ff;        // registered switch command
    logic        fault_n_ff;          // registered fault flag
    logic        oc_n_ff;             // registered overcurrent flag

    // map clamped resistor code into 15..150 v/ns
    function automatic logic [7:0] res_to_slew(input logic [7:0] code);
        logic [7:0] c;
        c = code;
        if (c < `SLEW_MIN) begin
            c = `SLEW_MIN;
        end
        if (c > `SLEW_MAX) begin
            c = `SLEW_MAX;
        end
        return c;
    endfunction

    // duty threshold from temperature code, linear per calibration line
    function automatic logic [13:0] temp_to_duty(input logic [11:0] code);
        logic [31:0] num;
        logic [31:0] d;
        num = 32'h0;
        d   = 32'h0;
        if (code > 12'(`TEMP_OFFSET_CODE)) begin
            num = 32'(code - 12'(`TEMP_OFFSET_CODE)) * 32'(`TEMP_PWM_PERIOD_CYC);
            d   = num / 32'(`TEMP_SLOPE_DEN);
        end
        if (d < 32'(`TEMP_MIN_PULSE_CYC)) begin
            d = 32'(`TEMP_MIN_PULSE_CYC);
        end
        if (d > 32'(`TEMP_PWM_PERIOD_CYC - 1)) begin
            d = 32'(`TEMP_PWM_PERIOD_CYC - 1);
        end
        return d[13:0];
    endfunction

    // axi handshake state
    logic        bvalid_ff;
    logic        rvalid_ff;
    logic [31:0] rdata_ff;
    logic        aw_seen_ff;
    logic        w_seen_ff;
    logic [7:0]  awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0]  wstrb_ff;

    wire         aw_take   = s_axi_awvalid & ~aw_seen_ff & ~bvalid_ff;
    wire         w_take    = s_axi_wvalid & ~w_seen_ff & ~bvalid_ff;
    wire         aw_have   = aw_seen_ff | aw_take;
    wire         w_have    = w_seen_ff | w_take;
    wire         wr_fire   = aw_have & w_have & ~bvalid_ff;
    wire [7:0]   wr_addr   = aw_seen_ff ? awaddr_ff : s_axi_awaddr;
    wire [31:0]  wr_data   = w_seen_ff ? wdata_ff : s_axi_wdata;
    wire [3:0]   wr_strb   = w_seen_ff ? wstrb_ff : s_axi_wstrb;
    wire         rd_fire   = s_axi_arvalid & ~rvalid_ff;
    wire         wr_hit    = (wr_addr == `REG_CTRL) | (wr_addr == `REG_THRESH)
                           | (wr_addr == `REG_BLANK) | (wr_addr == `REG_STATUS)
                           | (wr_addr == `REG_TEMP) | (wr_addr == `REG_SLEW);
    wire         rd_hit    = (s_axi_araddr == `REG_CTRL) | (s_axi_araddr == `REG_THRESH)
                           | (s_axi_araddr == `REG_BLANK) | (s_axi_araddr == `REG_STATUS)
                           | (s_axi_araddr == `REG_TEMP) | (s_axi_araddr == `REG_SLEW);

    assign s_axi_awready = ~aw_seen_ff & ~bvalid_ff;
    assign s_axi_wready  = ~w_seen_ff & ~bvalid_ff;
    assign s_axi_arready = ~rvalid_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    logic [1:0] bresp_ff;
    logic [1:0] rresp_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_rresp   = rresp_ff;

    // byte-lane merge for writable words
    wire [31:0] thresh_old = {4'h0, ot_clear_ff, 4'h0, ot_trip_ff};
    wire [31:0] blank_old  = {16'h0, blank_ff};
    wire [31:0] ctrl_old   = {31'h0, ctrl_ff};
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction
    wire [31:0] nxt_thresh = merge(thresh_old, wr_data, wr_strb);
    wire [31:0] nxt_blank  = merge(blank_old, wr_data, wr_strb);
    wire [31:0] nxt_ctrl   = merge(ctrl_old, wr_data, wr_strb);

    // write channel capture and response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_seen_ff <= 1'b0;
            w_seen_ff  <= 1'b0;
            awaddr_ff  <= 8'h00;
            wdata_ff   <= 32'h0;
            wstrb_ff   <= 4'h0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= 2'b00;
        end else begin
            if (wr_fire) begin
                aw_seen_ff <= 1'b0;
                w_seen_ff  <= 1'b0;
                bvalid_ff  <= 1'b1;
                bresp_ff   <= wr_hit ? 2'b00 : 2'b10;
            end else begin
                if (aw_take) begin
                    aw_seen_ff <= 1'b1;
                    awaddr_ff  <= s_axi_awaddr;
                end
                if (w_take) begin
                    w_seen_ff <= 1'b1;
                    wdata_ff  <= s_axi_wdata;
                    wstrb_ff  <= s_axi_wstrb;
                end
                if (bvalid_ff && s_axi_bready) begin
                    bvalid_ff <= 1'b0;
                end
            end
        end
    end

    // writable registers; status, temp and slew are read-only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ot_trip_ff  <= `OT_TRIP_RST;
            ot_clear_ff <= `OT_CLEAR_RST;
            blank_ff    <= `BLANK_RST;
            ctrl_ff     <= 1'b0;
        end else if (wr_fire) begin
            if (wr_addr == `REG_THRESH) begin
                ot_trip_ff  <= nxt_thresh[11:0];
                ot_clear_ff <= nxt_thresh[27:16];
            end
            if (wr_addr == `REG_BLANK) begin
                blank_ff <= nxt_blank[15:0];
            end
            if (wr_addr == `REG_CTRL) begin
                ctrl_ff <= nxt_ctrl[`CTRL_SIM_SEL_BIT];
            end
        end
    end

    // read mux
    wire [31:0] status_word = {21'h0, pwr_ff, idm_ff, thermal_shutdown_ff,
                               rail_lock_ff, fault_n_ff, oc_n_ff};
    wire [31:0] rd_word =
        (s_axi_araddr == `REG_CTRL)   ? ctrl_old :
        (s_axi_araddr == `REG_STATUS) ? status_word :
        (s_axi_araddr == `REG_TEMP)   ? {4'h0, temp_code, 2'b00, duty_ff} :
        (s_axi_araddr == `REG_SLEW)   ? {24'h0, slew_ff} :
        (s_axi_araddr == `REG_THRESH) ? thresh_old :
        (s_axi_araddr == `REG_BLANK)  ? blank_old : 32'h0;

    // read channel, one answer per address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h0;
            rresp_ff  <= 2'b00;
        end else if (rd_fire) begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= rd_word;
            rresp_ff  <= rd_hit ? 2'b00 : 2'b10;
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // drive-strength selection; strap sampled after reset release
    wire [15:0] res_ext = {slew_select_pin.res_code, 8'h00};
    wire [15:0] acc_up  = slew_acc_ff + 16'((res_ext - slew_acc_ff) >> `SLEW_FILT_SHIFT);
    wire [15:0] acc_dn  = slew_acc_ff - 16'((slew_acc_ff - res_ext) >> `SLEW_FILT_SHIFT);
    wire [15:0] nxt_acc = (res_ext >= slew_acc_ff) ? acc_up : acc_dn;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            strap_done_ff <= 1'b0;
            rail_lock_ff  <= 1'b0;
            slew_acc_ff   <= 16'h0;
            slew_ff       <= `SLEW_MAX;
        end else if (!strap_done_ff) begin
            strap_done_ff <= 1'b1;
            rail_lock_ff  <= slew_select_pin.tied_rail;
            slew_acc_ff   <= res_ext;
            if (slew_select_pin.tied_rail) begin
                slew_ff <= `SLEW_RAIL;
            end
        end else if (!rail_lock_ff) begin
            // heavy low-pass so switching noise cannot move the setting
            slew_acc_ff <= nxt_acc;
            if (slew_select_pin.tied_ground) begin
                slew_ff <= `SLEW_MAX;
            end else begin
                slew_ff <= res_to_slew(slew_acc_ff[15:8]);
            end
        end
    end
    assign slew_setting = slew_ff;

    // overtemperature latch with hysteresis
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            thermal_shutdown_ff <= 1'b0;
        end else if (temp_code >= ot_trip_ff) begin
            thermal_shutdown_ff <= 1'b1;
        end else if (temp_code < ot_clear_ff) begin
            thermal_shutdown_ff <= 1'b0;
        end
    end
    assign thermal_shutdown = thermal_shutdown_ff;

    // temperature pwm: free period counter, duty latched at wrap
    wire per_wrap = (per_cnt_ff == 14'(`TEMP_PWM_PERIOD_CYC - 1));
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            per_cnt_ff  <= 14'h0;
            duty_ff     <= 14'(`TEMP_MIN_PULSE_CYC);
            temp_pwm_ff <= 1'b0;
        end else begin
            per_cnt_ff <= per_wrap ? 14'h0 : per_cnt_ff + 14'h1;
            if (per_wrap) begin
                duty_ff <= temp_to_duty(temp_code);
            end
            if (thermal_shutdown_ff) begin
                temp_pwm_ff <= 1'b1;
            end else begin
                temp_pwm_ff <= (per_cnt_ff < duty_ff);
            end
        end
    end
    assign temp_pwm = temp_pwm_ff;

    // power-up sequencing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pwr_ff <= PWR_WAIT_SUPPLY;
        end else begin
            case (pwr_ff)
                PWR_WAIT_SUPPLY: begin
                    if (sense.supply_above_rise) begin
                        pwr_ff <= PWR_BUILD;
                    end
                end
                PWR_BUILD: begin
                    if (sense.supply_below_fall) begin
                        pwr_ff <= PWR_WAIT_SUPPLY;
                    end else if (sense.rail5_ok && sense.neg_rail_ok) begin
                        pwr_ff <= PWR_READY;
                    end
                end
                PWR_READY: begin
                    if (sense.supply_below_fall) begin
                        pwr_ff <= PWR_WAIT_SUPPLY;
                    end
                end
                default: begin
                    pwr_ff <= PWR_WAIT_SUPPLY;
                end
            endcase
        end
    end
    wire pwr_ok = (pwr_ff == PWR_READY);

    // ideal-diode state machine under overtemperature
    wire gate_fall = gate_d_ff & ~gate_in;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            idm_ff       <= IDM_OFF;
            blank_cnt_ff <= 16'h0;
            gate_d_ff    <= 1'b0;
        end else begin
            gate_d_ff <= gate_in;
            if (!thermal_shutdown_ff) begin
                idm_ff <= IDM_OFF;
            end else if (gate_fall) begin
                idm_ff       <= IDM_BLANK;
                blank_cnt_ff <= (blank_ff != 16'h0) ? blank_ff : 16'(BLANK_CYC);
            end else begin
                case (idm_ff)
                    IDM_OFF: begin
                        idm_ff <= IDM_WATCH;
                    end
                    IDM_BLANK: begin
                        if (blank_cnt_ff <= 16'h1) begin
                            idm_ff <= IDM_WATCH;
                        end else begin
                            blank_cnt_ff <= blank_cnt_ff - 16'h1;
                        end
                    end
                    IDM_WATCH: begin
                        if (sense.drain_negative) begin
                            idm_ff <= IDM_CONDUCT;
                        end
                    end
                    IDM_CONDUCT: begin
                        if (sense.drain_fwd_current) begin
                            idm_ff <= IDM_WATCH;
                        end
                    end
                    default: begin
                        idm_ff <= IDM_WATCH;
                    end
                endcase
            end
        end
    end

    // switch command and fault flags
    wire sc_fault = sense.short_circuit;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            switch_on_ff <= 1'b0;
            fault_n_ff   <= 1'b0;
            oc_n_ff      <= 1'b1;
        end else begin
            if (!pwr_ok || sc_fault) begin
                switch_on_ff <= 1'b0;
            end else if (thermal_shutdown_ff) begin
                switch_on_ff <= (idm_ff == IDM_CONDUCT);
            end else begin
                switch_on_ff <= gate_in & ~sense.overcurrent;
            end
            fault_n_ff <= pwr_ok & ~thermal_shutdown_ff
                        & ~sense.pin_open & ~sc_fault;
            oc_n_ff    <= ~(sense.overcurrent | sc_fault);
        end
    end
    assign switch_on          = switch_on_ff;
    assign fault_n            = fault_n_ff;
    assign overcurrent_flag_n = oc_n_ff;

endmodule
`default_nettype wire

/* hdl/gdrv_cfg.svh */
`ifndef GDRV_CFG_SVH
`define GDRV_CFG_SVH

// clock and timing
`define CLK_PERIOD_NS       8
`define TEMP_PWM_FREQ_HZ    9000
`define TEMP_PWM_PERIOD_CYC (125000000 / `TEMP_PWM_FREQ_HZ)
`define TEMP_MIN_PULSE_NS   30
`define TEMP_MIN_PULSE_CYC  ((`TEMP_MIN_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BLANK_CYC_DEFAULT   32
`define SLEW_FILT_SHIFT     8

// temperature code scaling: code is degrees c times 16, unsigned 12 bits
`define TEMP_FRAC_BITS      4
// duty = (t - 20.1) / 162.3, expressed as duty counts per code step
`define TEMP_OFFSET_CODE    322
`define TEMP_SLOPE_DEN      2597

// axi4-lite register byte offsets
`define REG_CTRL            8'h00
`define REG_STATUS          8'h04
`define REG_TEMP            8'h08
`define REG_SLEW            8'h0c
`define REG_THRESH          8'h10
`define REG_BLANK           8'h14

// control fields
`define CTRL_SIM_SEL_BIT    0

// reset values
`define OT_TRIP_RST         12'h9c4
`define OT_CLEAR_RST        12'h8fc
`define BLANK_RST           16'h0020

// slew codes in v/ns
`define SLEW_MAX            8'd150
`define SLEW_RAIL           8'd100
`define SLEW_MIN            8'd15

`endif

/* hdl/gdrv_pkg.sv */
package gdrv_pkg;

    // ideal-diode state machine, one-hot
    typedef enum logic [3:0] {
        IDM_OFF      = 4'b0001,
        IDM_BLANK    = 4'b0010,
        IDM_WATCH    = 4'b0100,
        IDM_CONDUCT  = 4'b1000
    } idm_state_t;

    // power-up sequencer, one-hot
    typedef enum logic [2:0] {
        PWR_WAIT_SUPPLY = 3'b001,
        PWR_BUILD       = 3'b010,
        PWR_READY       = 3'b100
    } pwr_state_t;

    // analog sense inputs grouped
    typedef struct packed {
        logic        supply_above_rise;
        logic        supply_below_fall;
        logic        rail5_ok;
        logic        neg_rail_ok;
        logic        drain_negative;
        logic        drain_fwd_current;
        logic        overcurrent;
        logic        short_circuit;
        logic        pin_open;
    } sense_t;

    // drive-strength strap observation
    typedef struct packed {
        logic        tied_ground;
        logic        tied_rail;
        logic [7:0]  res_code;
    } strap_t;

endpackage

/* test/gan_driver_ctrl_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module gan_driver_ctrl_bench;
    import gdrv_pkg::*;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic        gate_in;
    sense_t      sense = '0;
    strap_t      slew_select_pin = '0;
    logic [11:0] temp_code = 12'h190;
    logic        switch_on, thermal_shutdown, temp_pwm, fault_n, overcurrent_flag_n;
    logic [7:0]  slew_setting;
    logic        run = 1'b0, lvl = 1'b1;
    logic [15:0] width;
    logic [31:0] q;
    logic [1:0]  r;
    logic [11:0] code;
    int          fails = 0, checks = 0, seed = 22157, n;
    always #4 aclk = ~aclk;
    gan_driver_ctrl u_gan_driver_ctrl (.*);
    pwm_ctrl_model u_pwm_ctrl_model (.aclk, .run, .lvl, .temp_pwm, .gate_in, .width);
    task automatic cyc(input int k);
        repeat (k) @(posedge aclk);
    endtask
    task automatic look(input int k);
        repeat (k) @(posedge aclk);
        @(negedge aclk);
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // each valid held until its ready is seen at a rising edge
    task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rq, output logic [1:0] rr);
        logic aw, wv, ar;
        {aw, wv, ar} = {w, w, !w};
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        do begin
            s_axi_awvalid <= aw;
            s_axi_wvalid <= wv;
            s_axi_arvalid <= ar;
            @(posedge aclk);
            aw &= !s_axi_awready;
            wv &= !s_axi_wready;
            ar &= !s_axi_arready;
        end while ((w ? s_axi_bvalid : s_axi_rvalid) !== 1'b1);
        rq = s_axi_rdata;
        rr = w ? s_axi_bresp : s_axi_rresp;
    endtask
    function automatic logic [15:0] duty_exp(input logic [11:0] c);
        int d;
        d = (int'(c) - 322) * 13888 / 2597;
        return (d < 4) ? 16'h0004 : 16'(d);
    endfunction
    task automatic stop_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (90000) @(posedge aclk);
        fails++;
        stop_test();
    end
    initial begin
        look(9);
        chk("fault in reset", 0, fault_n);
        chk("switch in reset", 0, switch_on);
        cyc(1);
        aresetn <= 1'b1;
        sense.supply_above_rise <= 1'b1;
        cyc(3);
        sense.supply_above_rise <= 1'b0;
        sense.supply_below_fall <= 1'b1;
        sense.rail5_ok <= 1'b1;
        sense.neg_rail_ok <= 1'b1;
        look(20);
        chk("fault paused", 0, fault_n);
        cyc(1);
        sense.supply_below_fall <= 1'b0;
        sense.supply_above_rise <= 1'b1;
        for (n = 0; n < 200 && fault_n !== 1'b1; n++) @(posedge aclk);
        chk("fault released", 1, fault_n);
        $display("power-up test done");
        axi(1'b0, 8'h10, 32'h0, q, r);
        chk("thresholds", 32'h08fc09c4, q);
        axi(1'b0, 8'h14, 32'h0, q, r);
        chk("blanking", 32'h00000020, q);
        axi(1'b0, 8'h40, 32'h0, q, r);
        chk("unmapped read", 2'b10, r);
        axi(1'b1, 8'h40, 32'h1, q, r);
        chk("unmapped write", 2'b10, r);
        axi(1'b1, 8'h00, 32'h1, q, r);
        axi(1'b0, 8'h00, 32'h0, q, r);
        chk("ctrl", 32'h1, q);
        $display("register test done");
        slew_select_pin.res_code <= 8'(15 + $unsigned($random(seed)) % 136);
        slew_select_pin.tied_ground <= 1'b1;
        run <= 1'b1;
        look(300);
        chk("grounded slew", 8'h96, slew_setting);
        cyc(1);
        slew_select_pin.tied_ground <= 1'b0;
        $display("slew test done");
        for (int i = 0; i < 2; i++) begin
            code = (i == 0) ? 12'(400 + $unsigned($random(seed)) % 2001) : 12'h0c8;
            temp_code <= code;
            cyc(2 * 13888 + 20);
            chk("temp duty", duty_exp(code), width);
        end
        $display("temperature test done");
        run <= 1'b0;
        lvl <= 1'b1;
        cyc(5);
        temp_code <= 12'h9d4;
        for (n = 0; n < 50 && thermal_shutdown !== 1'b1; n++) @(posedge aclk);
        @(negedge aclk);
        chk("shutdown", 1, thermal_shutdown);
        chk("fault hot", 0, fault_n);
        look(2);
        chk("temp held", 1, temp_pwm);
        cyc(1);
        lvl <= 1'b0;
        cyc(3);
        sense.drain_negative <= 1'b1;
        look(2);
        chk("off after fall", 0, switch_on);
        look(20);
        chk("off in blank", 0, switch_on);
        for (n = 0; n < 40 && switch_on !== 1'b1; n++) @(posedge aclk);
        chk("diode on", 1, switch_on);
        sense.drain_fwd_current <= 1'b1;
        sense.drain_negative <= 1'b0;
        look(3);
        chk("diode off", 0, switch_on);
        cyc(1);
        sense.drain_fwd_current <= 1'b0;
        temp_code <= 12'h900;
        look(20);
        chk("hysteresis", 1, thermal_shutdown);
        cyc(1);
        temp_code <= 12'h8f0;
        for (n = 0; n < 50 && fault_n !== 1'b1; n++) @(posedge aclk);
        chk("cooled", 0, thermal_shutdown);
        $display("shutdown test done");
        sense.overcurrent <= 1'b1;
        look(3);
        chk("oc flag", 0, overcurrent_flag_n);
        chk("oc fault", 1, fault_n);
        cyc(1);
        sense.short_circuit <= 1'b1;
        look(3);
        chk("short fault", 0, fault_n);
        cyc(1);
        sense.overcurrent <= 1'b0;
        sense.short_circuit <= 1'b0;
        slew_select_pin.tied_rail <= 1'b1;
        aresetn <= 1'b0;
        cyc(10);
        aresetn <= 1'b1;
        look(5);
        chk("rail slew", 8'h64, slew_setting);
        cyc(1);
        slew_select_pin.tied_rail <= 1'b0;
        slew_select_pin.tied_ground <= 1'b1;
        look(300);
        chk("rail locked", 8'h64, slew_setting);
        $display("fault and strap test done");
        stop_test();
    end
endmodule
bind gan_driver_ctrl gdrv_props #(.BLANK_CYC(BLANK_CYC)) u_gdrv_props (.aclk, .aresetn, .gate_in,
    .sense, .slew_select_pin, .switch_on, .thermal_shutdown, .temp_pwm, .fault_n,
    .overcurrent_flag_n, .slew_setting);
`default_nettype wire

/* test/gdrv_props.sv */
`timescale 1ns/1ps
`default_nettype none
module gdrv_props
    import gdrv_pkg::*;
#(
    parameter int BLANK_CYC = 32
) (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       gate_in,
    input wire sense_t     sense,
    input wire strap_t     slew_select_pin,
    input wire logic       switch_on,
    input wire logic       thermal_shutdown,
    input wire logic       temp_pwm,
    input wire logic       fault_n,
    input wire logic       overcurrent_flag_n,
    input wire logic [7:0] slew_setting
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [15:0] fall_age_ff; // cycles since a gate fall during thermal shutdown, saturating
    always_ff @(posedge aclk) begin
        if (!aresetn)
            fall_age_ff <= 16'hffff;
        else if ($fell(gate_in) && thermal_shutdown)
            fall_age_ff <= 16'h0000;
        else if (fall_age_ff != 16'hffff)
            fall_age_ff <= fall_age_ff + 16'h0001;
    end
    property p_rail; $rose(aresetn) && slew_select_pin.tied_rail |-> ##[1:3] slew_setting == 8'h64; endproperty
    a_rail: assert property (p_rail) else $error("rail slew");
    property p_range; slew_setting >= 8'h0f && slew_setting <= 8'h96; endproperty
    a_range: assert property (p_range) else $error("slew out of range");
    property p_ready; $rose(fault_n) |-> $past(sense.rail5_ok) && $past(sense.neg_rail_ok); endproperty
    a_ready: assert property (p_ready) else $error("early fault release");
    property p_hot; thermal_shutdown |=> temp_pwm; endproperty
    a_hot: assert property (p_hot) else $error("temp not held high");
    property p_pulse; $rose(temp_pwm) |-> temp_pwm[*4]; endproperty
    a_pulse: assert property (p_pulse) else $error("temp pulse too short");
    property p_follow; (fault_n && overcurrent_flag_n && !thermal_shutdown)[*3] |-> switch_on == $past(gate_in); endproperty
    a_follow: assert property (p_follow) else $error("switch not following");
    property p_blank; thermal_shutdown && $rose(switch_on) |-> fall_age_ff >= BLANK_CYC - 1; endproperty
    a_blank: assert property (p_blank) else $error("on inside blanking");
    property p_fwd; thermal_shutdown && switch_on && sense.drain_fwd_current |-> ##[1:2] (!switch_on || !thermal_shutdown); endproperty
    a_fwd: assert property (p_fwd) else $error("on with forward current");
    property p_short; sense.short_circuit |-> ##[1:2] (!fault_n && !overcurrent_flag_n); endproperty
    a_short: assert property (p_short) else $error("short not flagged");
    property p_oc; sense.overcurrent |-> ##[1:2] !overcurrent_flag_n; endproperty
    a_oc: assert property (p_oc) else $error("overcurrent not flagged");
endmodule
`default_nettype wire

/* test/pwm_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pwm_ctrl_model (
    input  wire logic   aclk,
    input  wire logic   run,       // toggle the gate every eight cycles
    input  wire logic   lvl,       // gate level while not switching
    input  wire logic   temp_pwm,
    output logic        gate_in,
    output logic [15:0] width      // last measured temp high time in cycles
);
    logic [2:0]  ph_ff;
    logic [15:0] hi_ff;
    initial begin
        gate_in = 1'b0;
        ph_ff = 3'h0;
        hi_ff = 16'h0000;
        width = 16'h0000;
    end
    always @(posedge aclk) begin
        ph_ff <= run ? ph_ff + 3'h1 : 3'h0;
        if (!run)
            gate_in <= lvl;
        else if (ph_ff == 3'h5)
            gate_in <= ~gate_in;
        hi_ff <= temp_pwm ? hi_ff + 16'h0001 : 16'h0000;
        if (!temp_pwm && hi_ff != 16'h0000)
            width <= hi_ff;
    end
endmodule
`default_nettype wire
